// [fpm_csr.sv]
// Buffer level and power management control registers
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_csr #(
   parameter int unsigned TRANSCEIVER_RESET_CYCLES = `FPM_TRANSCEIVER_RESET_CYCLES,
   parameter int unsigned WAKE_PULSE_CYCLES = `FPM_WAKE_PULSE_CYCLES,
   parameter int unsigned READY_SETTLE = `FPM_READY_SETTLE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input fpm_pkg::fpm_host_req_t hostReq,
   output logic [31:0] hostRdata,
   output logic hostRvalid,
   input fpm_pkg::fpm_level_t levels,
   input wire logic lanWakeEvent,
   input wire logic energyDetectEvent,
   output logic transceiverReset,
   output logic wakeInterrupt,
   output logic wakeOutput,
   output logic wakeOutputOeN,
   output logic deviceReady,
   output fpm_pkg::fpm_state_t powerState
);
   initial
   begin
      if (READY_SETTLE < 1 || READY_SETTLE > 255 || TRANSCEIVER_RESET_CYCLES < 1)
         $error("fpm_csr parameters out of range");
   end
   // ****************************************
   // Register decode and read mux
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit
   fpm_pkg::fpm_level_t lvl_q, lvl_d;
   fpm_pkg::fpm_wake_cfg_t cfg_q, cfg_d;
   fpm_pkg::fpm_state_t state_q, state_d;
   logic readSeen_q, readSeen_d;
   logic ready_q, ready_d;
   logic [7:0] settle_q, settle_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic wakeLatch_q, wakeLatch_d;
   logic wakeInt_q, wakeInt_d;
   logic pinOut_q, pinOut_d;
   logic pinOeN_q, pinOeN_d;
   logic phyStart, phyBusy, pulseStart, pulseBusy;
   logic wrOk, wakeEvent, active;
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      rvalid_d = hostReq.rd;
      if (hit(hostReq.addr, `FPM_OFS_PM_CTRL))
      begin
         // PM control answers in any power state
         rdata_d[`FPM_BIT_STATE_HI:`FPM_BIT_STATE_LO] = state_q;
         rdata_d[`FPM_BIT_TRANSCEIVER_RESET] = phyBusy;
         rdata_d[`FPM_BIT_LAN_WAKE] = cfg_q.lanWakeEnable;
         rdata_d[`FPM_BIT_ENERGY] = cfg_q.energyDetectEnable;
         rdata_d[`FPM_BIT_BUF_SEL] = cfg_q.wakeOutputBufferSelect;
         rdata_d[`FPM_BIT_PULSE] = cfg_q.wakeOutputPulseMode;
         rdata_d[`FPM_BIT_POL] = cfg_q.wakeOutputPolarity;
         rdata_d[`FPM_BIT_OUT_EN] = cfg_q.wakeOutputEnable;
         rdata_d[`FPM_BIT_READY] = ready_q;
      end
      else if (ready_q && hit(hostReq.addr, `FPM_OFS_RX_LEVEL))
      begin
         rdata_d[`FPM_STAT_HI:`FPM_STAT_LO] = lvl_q.rxStatusWordsUsed;
         rdata_d[`FPM_DATA_HI:`FPM_DATA_LO] = lvl_q.rxDataBytesUsed;
      end
      else if (ready_q && hit(hostReq.addr, `FPM_OFS_TX_LEVEL))
      begin
         rdata_d[`FPM_STAT_HI:`FPM_STAT_LO] = lvl_q.txStatusWordsUsed;
         rdata_d[`FPM_DATA_HI:`FPM_DATA_LO] = lvl_q.txDataBytesFree;
      end
   end
   // ****************************************
   // Control state
   // ****************************************
   assign wrOk = hostReq.wr && readSeen_q && ready_q;
   assign phyStart = wrOk && !phyBusy && hit(hostReq.addr, `FPM_OFS_PM_CTRL)
      && hostReq.wdata[`FPM_BIT_TRANSCEIVER_RESET];
   assign wakeEvent = (lanWakeEvent && cfg_q.lanWakeEnable)
      || (energyDetectEvent && cfg_q.energyDetectEnable);
   assign pulseStart = wakeEvent && cfg_q.wakeOutputPulseMode;
   always_comb
   begin
      lvl_d = levels;
      cfg_d = cfg_q;
      state_d = state_q;
      readSeen_d = readSeen_q || hostReq.rd;
      settle_d = settle_q;
      wakeInt_d = wakeEvent;
      if (wrOk && hit(hostReq.addr, `FPM_OFS_PM_CTRL))
      begin
         cfg_d.lanWakeEnable = hostReq.wdata[`FPM_BIT_LAN_WAKE];
         cfg_d.energyDetectEnable = hostReq.wdata[`FPM_BIT_ENERGY];
         cfg_d.wakeOutputBufferSelect = hostReq.wdata[`FPM_BIT_BUF_SEL];
         cfg_d.wakeOutputPulseMode = hostReq.wdata[`FPM_BIT_PULSE];
         cfg_d.wakeOutputPolarity = hostReq.wdata[`FPM_BIT_POL];
         cfg_d.wakeOutputEnable = hostReq.wdata[`FPM_BIT_OUT_EN];
         case (hostReq.wdata[`FPM_BIT_STATE_HI:`FPM_BIT_STATE_LO])
            2'h1: state_d = fpm_pkg::STATE_FRAME_WAKE;
            2'h2: state_d = fpm_pkg::STATE_ENERGY_WAKE;
            default: state_d = state_q;
         endcase
      end
      if (state_q != fpm_pkg::STATE_NORMAL && hostReq.wr
         && hit(hostReq.addr, `FPM_OFS_WAKE_WRITE))
      begin
         state_d = fpm_pkg::STATE_NORMAL;
         readSeen_d = 1'b0;
      end
      if (state_d != fpm_pkg::STATE_NORMAL)
         settle_d = 8'h00;
      else if (settle_q != 8'(READY_SETTLE))
         settle_d = settle_q + 8'h01;
      ready_d = (state_d == fpm_pkg::STATE_NORMAL)
         && (settle_d == 8'(READY_SETTLE));
      // Set wins over clearing by the enables
      wakeLatch_d = wakeLatch_q;
      if (!cfg_q.wakeOutputEnable
         || !(cfg_q.lanWakeEnable || cfg_q.energyDetectEnable))
         wakeLatch_d = 1'b0;
      if (wakeEvent)
         wakeLatch_d = 1'b1;
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl_q <= '{8'h00, 16'h0000, 8'h00, `FPM_TX_FREE_RESET};
         cfg_q <= '0;
         state_q <= fpm_pkg::STATE_NORMAL;
         readSeen_q <= 1'b0;
         settle_q <= 8'h00;
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
         wakeLatch_q <= 1'b0;
         wakeInt_q <= 1'b0;
      end
      else
      begin
         lvl_q <= lvl_d;
         cfg_q <= cfg_d;
         state_q <= state_d;
         readSeen_q <= readSeen_d;
         settle_q <= settle_d;
         ready_q <= ready_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         wakeLatch_q <= wakeLatch_d;
         wakeInt_q <= wakeInt_d;
      end
   end
   // ****************************************
   // Timers and wake pin
   // ****************************************
   fpm_timer #(.COUNT(TRANSCEIVER_RESET_CYCLES)) phyTimer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(phyStart),
      .busy(phyBusy)
   );
   fpm_timer #(.COUNT(WAKE_PULSE_CYCLES)) pulseTimer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(pulseStart),
      .busy(pulseBusy)
   );
   assign active = cfg_q.wakeOutputEnable && (cfg_q.wakeOutputPulseMode
      ? pulseBusy : wakeLatch_q);
   always_comb
   begin
      if (cfg_q.wakeOutputBufferSelect)
      begin
         pinOeN_d = 1'b0;
         pinOut_d = cfg_q.wakeOutputPolarity ? active : !active;
      end
      else
      begin
         pinOeN_d = !active;
         pinOut_d = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinOut_q <= 1'b0;
         pinOeN_q <= 1'b1;
      end
      else
      begin
         pinOut_q <= pinOut_d;
         pinOeN_q <= pinOeN_d;
      end
   end
   assign hostRdata = rdata_q;
   assign hostRvalid = rvalid_q;
   assign transceiverReset = phyBusy;
   assign wakeInterrupt = wakeInt_q;
   assign wakeOutput = pinOut_q;
   assign wakeOutputOeN = pinOeN_q;
   assign deviceReady = ready_q;
   assign powerState = state_q;
   // ****************************************
   // Assertions
   // ****************************************
   int unsigned phyCnt;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         phyCnt <= 0;
      else
         phyCnt <= phyBusy ? phyCnt + 1 : 0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence sWakeWrite;
      state_q != fpm_pkg::STATE_NORMAL && hostReq.wr
         && hit(hostReq.addr, `FPM_OFS_WAKE_WRITE);
   endsequence
   sequence sPmRead;
      hostReq.rd && hit(hostReq.addr, `FPM_OFS_PM_CTRL);
   endsequence
   AST_PHY_HOLD: assert property ($fell(phyBusy) |-> phyCnt == TRANSCEIVER_RESET_CYCLES)
      else $error("transceiver reset length wrong");
   AST_PHY_IGNORE: assert property (phyCnt <= TRANSCEIVER_RESET_CYCLES)
      else $error("transceiver reset retriggered");
   AST_WRITE_LOCK: assert property (!readSeen_q && hostReq.wr |=> $stable(cfg_q))
      else $error("write acted before first read");
   AST_WAKE: assert property (sWakeWrite |=> state_q == fpm_pkg::STATE_NORMAL
      && !readSeen_q ##1 !deviceReady)
      else $error("wake write did not wake");
   AST_READY_LOW: assert property (powerState != fpm_pkg::STATE_NORMAL
      |-> !deviceReady)
      else $error("ready while in reduced power");
   AST_PM_READ: assert property (sPmRead |=> hostRvalid
      && hostRdata[13:12] == $past(state_q))
      else $error("power control read failed");
   AST_LAN_INT: assert property (lanWakeEvent && cfg_q.lanWakeEnable
      |=> wakeInterrupt)
      else $error("lan wake interrupt missing");
   AST_ENERGY_INT: assert property (energyDetectEvent
      && cfg_q.energyDetectEnable |=> wakeInterrupt)
      else $error("energy wake interrupt missing");
   AST_OPEN_DRAIN: assert property (!cfg_q.wakeOutputBufferSelect
      && $stable(cfg_q) |=> !wakeOutput)
      else $error("open drain pin driven high");
   AST_TX_FREE: assert property (hostReq.rd && ready_q
      && hit(hostReq.addr, `FPM_OFS_TX_LEVEL)
      |=> hostRdata[15:0] == $past(levels.txDataBytesFree, 2))
      else $error("free space read stale");
endmodule : fpm_csr

// [fpm_defines.svh]
// Offsets, field positions, reset values and timing counts
// Operation
// - Receive status occupancy, bits 23-16, in words, read-only, resets zero.
// - Receive data occupancy, bits 15-0, bytes, word-rounded per frame, resets zero.
// - Transmit status occupancy, bits 23-16, in words, read-only.
// - Transmit data free space, bits 15-0, bytes, read-only, resets 0x1200.
// - Power control register stays readable in every reduced power state.
// - After reset or wake, writes are ignored until one read occurs.
// - Self-clearing power state field bits 13-12; 00 normal, 01, 10; 11 reserved.
// - In reduced power, any write to the wake address wakes the device.
// - Writing one to bit 10 holds transceiver reset 100 us, then self-clears.
// - Writes to the transceiver reset bit are ignored while it reads high.
// - Lan wake event with enable drives wake output if enabled, per mode.
// - Lan wake event with enable raises wake interrupt regardless of output enable.
// - Energy event with enable drives wake output if enabled, always interrupts.
// - Bit 6 selects push-pull; open-drain ignores polarity, active low.
// - Read-only ready bit 0 sets once device has stabilised.
// - Pulse mode gives a 50 ms wake pulse; otherwise driven continuously.
// - Wake output enable gates only the pin, never the interrupt.
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
`define FPM_OFS_RX_LEVEL 8'h7C
`define FPM_OFS_TX_LEVEL 8'h80
`define FPM_OFS_PM_CTRL 8'h84
`define FPM_OFS_WAKE_WRITE 8'h64
`define FPM_STAT_HI 23
`define FPM_STAT_LO 16
`define FPM_DATA_HI 15
`define FPM_DATA_LO 0
`define FPM_BIT_STATE_HI 13
`define FPM_BIT_STATE_LO 12
`define FPM_BIT_TRANSCEIVER_RESET 10
`define FPM_BIT_LAN_WAKE 9
`define FPM_BIT_ENERGY 8
`define FPM_BIT_BUF_SEL 6
`define FPM_BIT_PULSE 3
`define FPM_BIT_POL 2
`define FPM_BIT_OUT_EN 1
`define FPM_BIT_READY 0
`define FPM_TX_FREE_RESET 16'h1200
`define FPM_CLK_PERIOD_NS 20
`define FPM_TRANSCEIVER_RESET_TIME_NS 100000
`define FPM_WAKE_PULSE_TIME_NS 50000000
`define FPM_TRANSCEIVER_RESET_CYCLES \
   ((`FPM_TRANSCEIVER_RESET_TIME_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_WAKE_PULSE_CYCLES (`FPM_WAKE_PULSE_TIME_NS / `FPM_CLK_PERIOD_NS)
`define FPM_READY_SETTLE_CYCLES 8
`endif

// [fpm_host_model.sv]
// Host processor model issuing register read and write cycles
`timescale 1ns/1ps
module fpm_host_model (
   input wire logic clk_sys,
   input wire logic [31:0] hostRdata,
   input wire logic hostRvalid,
   output fpm_pkg::fpm_host_req_t hostReq
);
   initial hostReq = '0;
   // One-cycle write pulse; bus inverted after release
   // Bench keeps pushes in free space, wake address only when not ready
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      #1;
      hostReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys);
      #1;
      hostReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask : write
   // One-cycle read pulse; data taken with the valid pulse
   task automatic read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      #1;
      hostReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
      @(posedge clk_sys);
      #1;
      hostReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hFFFFFFFF};
      d = (hostRvalid === 1'b1) ? hostRdata : 32'hX;
   endtask : read
endmodule : fpm_host_model

// [fpm_pkg.sv]
// Types shared by the level and power control registers
package fpm_pkg;
   typedef enum logic [1:0] {
      STATE_NORMAL,
      STATE_FRAME_WAKE,
      STATE_ENERGY_WAKE
   } fpm_state_t;
   typedef struct packed {
      logic [7:0] rxStatusWordsUsed;
      logic [15:0] rxDataBytesUsed;
      logic [7:0] txStatusWordsUsed;
      logic [15:0] txDataBytesFree;
   } fpm_level_t;
   typedef struct packed {
      logic lanWakeEnable;
      logic energyDetectEnable;
      logic wakeOutputBufferSelect;
      logic wakeOutputPulseMode;
      logic wakeOutputPolarity;
      logic wakeOutputEnable;
   } fpm_wake_cfg_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } fpm_host_req_t;
endpackage : fpm_pkg

// [fpm_timer.sv]
// One-shot down counter busy for a fixed number of cycles
`timescale 1ns/1ps
module fpm_timer #(
   parameter int unsigned COUNT = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   output logic busy
);
   localparam int unsigned W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   initial
   begin
      if (COUNT < 1)
         $error("fpm_timer COUNT must be at least one");
   end
   always_comb
   begin
      cnt_d = cnt_q;
      if (cnt_q != '0)
         cnt_d = cnt_q - W'(1);
      else if (start)
         cnt_d = W'(COUNT);
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
   assign busy = (cnt_q != '0);
endmodule : fpm_timer

// [tb_top.sv]
// Self-checking bench for the level and power control registers
`timescale 1ns/1ps
`include "fpm_defines.svh"
module tb_top;
   localparam logic [7:0] PM = `FPM_OFS_PM_CTRL;
   localparam int unsigned PHY_CYC = 10;
   localparam int unsigned PULSE_CYC = 20;
   logic clk_sys, rst_n, lanWakeEvent, energyDetectEvent;
   logic hostRvalid, transceiverReset, wakeInterrupt, wakeOutput;
   logic wakeOutputOeN, deviceReady;
   logic [31:0] hostRdata, rd;
   fpm_pkg::fpm_host_req_t hostReq;
   fpm_pkg::fpm_level_t levels;
   fpm_pkg::fpm_state_t powerState;
   int errors, checks_done, cycles, rstCnt, irq, hi, od;
   fpm_csr #(.TRANSCEIVER_RESET_CYCLES(PHY_CYC), .WAKE_PULSE_CYCLES(PULSE_CYC),
      .READY_SETTLE(8)) fpm_csr_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .hostReq(hostReq), .hostRdata(hostRdata), .hostRvalid(hostRvalid),
      .levels(levels), .lanWakeEvent(lanWakeEvent),
      .energyDetectEvent(energyDetectEvent),
      .transceiverReset(transceiverReset), .wakeInterrupt(wakeInterrupt),
      .wakeOutput(wakeOutput), .wakeOutputOeN(wakeOutputOeN),
      .deviceReady(deviceReady), .powerState(powerState));
   fpm_host_model fpm_host_model_i (.clk_sys(clk_sys),
      .hostRdata(hostRdata), .hostRvalid(hostRvalid), .hostReq(hostReq));
   // ****************
   // Clock and watchdog
   // ****************
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         end_sim();
      end
   end
   // Reset length counted away from the launching edge
   always @(negedge clk_sys)
   begin
      if (transceiverReset === 1'b1)
         rstCnt++;
   end
   // ****************
   // Helpers
   // ****************
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      fpm_host_model_i.read(a, rd);
      check(what, exp, rd);
   endtask : rchk
   task automatic waitReady();
      for (int n = 0; n < 40 && deviceReady !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check("ready", 32'h1, deviceReady);
   endtask : waitReady
   // Fire one event cycle, then count interrupts and pin drive levels
   task automatic fire(input bit lan, input int win);
      irq = 0;
      hi = 0;
      od = 0;
      @(posedge clk_sys);
      #1;
      lanWakeEvent = lan;
      energyDetectEvent = !lan;
      repeat (win)
      begin
         @(posedge clk_sys);
         #1;
         lanWakeEvent = 1'b0;
         energyDetectEvent = 1'b0;
         irq += (wakeInterrupt === 1'b1);
         hi += (wakeOutputOeN === 1'b0 && wakeOutput === 1'b1);
         od += (wakeOutputOeN === 1'b0 && wakeOutput === 1'b0);
      end
   endtask : fire
   task automatic end_sim();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      rst_n = 1'b0;
      lanWakeEvent = 1'b0;
      energyDetectEvent = 1'b0;
      levels = '{8'h00, 16'h0000, 8'h00, 16'h1200};
      repeat (10) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      rchk("pm early", PM, 32'h0);
      waitReady();
      rchk("pm idle", PM, 32'h1);
      levels = '{8'h12, 16'h0044, 8'h03, 16'h11FC};
      rchk("rx level", `FPM_OFS_RX_LEVEL, 32'h00120044);
      rchk("tx level", `FPM_OFS_TX_LEVEL, 32'h000311FC);
      levels = '{8'hFF, 16'hFFFC, 8'h80, 16'h0000};
      rchk("rx full", `FPM_OFS_RX_LEVEL, 32'h00FFFFFC);
      rchk("tx full", `FPM_OFS_TX_LEVEL, 32'h00800000);
      rchk("unmapped", 8'h88, 32'h0);
      fpm_host_model_i.write(PM, 32'h246);
      rchk("pm cfg", PM, 32'h247);
      fire(1'b1, 30);
      check("lan irq", 32'd1, irq);
      check("static pin", 32'd1, hi >= 28);
      fpm_host_model_i.write(PM, 32'h100);
      fire(1'b0, 10);
      check("energy irq", 32'd1, irq);
      check("pin gated", 32'd0, hi + od);
      fpm_host_model_i.write(PM, 32'h106);
      fire(1'b0, 10);
      check("open drain", 32'd1, od >= 8 && hi == 0);
      fpm_host_model_i.write(PM, 32'h0);
      fpm_host_model_i.write(PM, 32'h24E);
      fire(1'b1, 40);
      check("pulse width", PULSE_CYC, hi);
      fpm_host_model_i.write(PM, 32'h242);
      fire(1'b1, 10);
      check("active low push", 32'd1, od >= 8 && hi == 0);
      rstCnt = 0;
      fpm_host_model_i.write(PM, 32'h400);
      rchk("phy busy", PM, 32'h401);
      fpm_host_model_i.write(PM, 32'h400);
      repeat (20) @(posedge clk_sys);
      #1;
      check("phy hold", PHY_CYC, rstCnt);
      rchk("phy clear", PM, 32'h1);
      fpm_host_model_i.write(PM, 32'h1000);
      check("frame wake", fpm_pkg::STATE_FRAME_WAKE, powerState);
      rchk("pm asleep", PM, 32'h1000);
      fpm_host_model_i.write(`FPM_OFS_WAKE_WRITE, 32'h5A);
      check("woken", fpm_pkg::STATE_NORMAL, powerState);
      waitReady();
      fpm_host_model_i.write(PM, 32'h2);
      rchk("no first read", PM, 32'h1);
      fpm_host_model_i.write(PM, 32'h2000);
      check("energy wake", fpm_pkg::STATE_ENERGY_WAKE, powerState);
      fpm_host_model_i.write(`FPM_OFS_WAKE_WRITE, 32'h0);
      waitReady();
      rchk("pm woken", PM, 32'h1);
      fpm_host_model_i.write(PM, 32'h3000);
      check("reserved state", fpm_pkg::STATE_NORMAL, powerState);
      end_sim();
   end
endmodule : tb_top
